// ==== sfs_pkg.sv ====
// sfs_pkg: opcodes, status layout, timing counts and state types of the flash sequencer
// assumes a 200 MHz core clock; every serial pin is sampled by that clock
package sfs_pkg;
  // command opcodes
  localparam logic [7:0] OP_STATUS_WRITE = 8'h01;
  localparam logic [7:0] OP_READ         = 8'h03;
  localparam logic [7:0] OP_FAST         = 8'h0b;
  localparam logic [7:0] OP_DUAL         = 8'h3b;
  localparam logic [7:0] OP_ERASE        = 8'h20;
  localparam logic [7:0] OP_UNLOCK       = 8'h06;
  // status byte layout
  localparam int LOCK_BIT  = 7;
  localparam int ZERO_BIT  = 6;
  localparam int PROT_MSB  = 5;
  localparam int PROT_LSB  = 2;
  localparam int LATCH_BIT = 1;
  localparam int BUSY_BIT  = 0;
  localparam logic       LOCK_RST = 1'b0;
  localparam logic [3:0] PROT_RST = 4'h0;
  // timing: times in microseconds, counts derived from the clock rate
  localparam int          CLK_MHZ               = 200;
  localparam int          STATUS_WRITE_TIME_US  = 10;
  localparam int          ERASE4K_TIME_US       = 45;
  localparam int unsigned STATUS_WRITE_CYC      = STATUS_WRITE_TIME_US * CLK_MHZ;
  localparam int unsigned ERASE4K_CYC           = ERASE4K_TIME_US * CLK_MHZ;
  // geometry
  localparam int          MEM_ADDR_W  = 21;
  localparam int          SECTOR_LSB  = 12;
  localparam logic [12:0] SECTOR_DONE = 13'h1000;
  localparam int          BLOCK_LSB   = 16;
  localparam logic [1:0]  ADDR_LAST   = 2'd2;
  localparam int          FIFO_DEPTH  = 32;

  typedef struct packed {
    logic guard_n;
    logic cs_n;
    logic sclk;
    logic si;
  } sfs_pins_s;

  typedef enum logic [2:0] {PH_CMD, PH_ADDR, PH_DUMMY, PH_DATA, PH_STAT, PH_SKIP} sfs_phase_e;
  typedef enum logic [1:0] {PD_NONE, PD_UNLOCK, PD_STATUS, PD_ERASE} sfs_pend_e;

  typedef struct packed {
    sfs_pins_s   s1;
    sfs_pins_s   s2;
    logic        sclk_d;
    logic        cs_d;
    sfs_phase_e  ph;
    logic [2:0]  bitcnt;
    logic [1:0]  bytecnt;
    logic [7:0]  sh;
    logic [7:0]  cmd;
    logic [7:0]  new_stat;
    logic [23:0] addr;
    logic [23:0] pf_addr;
    logic        pf_en;
    sfs_pend_e   pend;
    logic        lock;
    logic [3:0]  prot;
    logic        latch;
    logic        busy;
    logic [31:0] timer;
    logic [12:0] er_idx;
    logic [11:0] er_base;
    logic [7:0]  obyte;
    logic [2:0]  obit;
    logic        io1;
    logic        io0;
    logic        oe1;
    logic        oe0;
    logic [7:0]  status;
    logic        hgm;
  } sfs_state_s;
endpackage

// ==== sfs_core.sv ====
// sfs_core: serial flash command engine with read prefetch fifo and self-timed cycles
// assumes cs_n, sclk, data and guard pins are asynchronous; sclk slower than mclk/8
// Behaviour
// R1 - status write ignored unless the write latch was set beforehand
// R2 - status write is opcode 01h plus exactly one status byte
// R3 - status write leaves bits 6, 1 and 0 untouched
// R4 - valid status write starts timed busy cycle, then clears write latch
// R5 - lock bit set with guard pin low rejects every status write
// R6 - otherwise an enabled status write changes lock and protect level bits
// R7 - hard guard mode is lock bit and guard low; only guard high exits
// R8 - read is 03h plus 3 address bytes; sample on rise, shift on fall
// R9 - read address increments per byte and wraps to zero at the top
// R10 - chip select high ends a read and releases the data lines
// R11 - fast read is 0Bh, 3 address bytes, one dummy byte, then data
// R12 - fast and dual reads rejected while a timed cycle runs
// R13 - dual read is 3Bh, address, 8 dummy clocks, two bits per fall
// R14 - two-line output is used only for dual read data
// R15 - erase 20h plus address needs latch; clears the 4K sector to ones
// R16 - status write and erase execute only if select rises on byte boundary
// R17 - erase runs timed busy cycle, then clears the write latch
// R18 - erase into the protected area is not performed
// R19 - status byte: lock, zero, protect level, latch, busy from bit 7 down
// R20 - opcode 06h alone sets the write latch
// R21 - all bytes are shifted most significant bit first
`timescale 1ns/100ps

module sfs_fifo #(
  parameter int W = 8,                        // word width
  parameter int D = 32                        // depth, power of two
) (
  input  wire logic         clk_i,            // core clock
  input  wire logic         reset_i,          // synchronous reset
  input  wire logic         flush_i,          // drop all words
  input  wire logic         in_valid_i,       // push request
  output logic              in_ready_o,       // room for a word
  input  wire logic [W-1:0] in_data_i,        // pushed word
  output logic              out_valid_o,      // word available
  input  wire logic         out_ready_i,      // pop request
  output logic [W-1:0]      out_data_o        // head word
);
  localparam int AW = $clog2(D);
  typedef struct packed {
    logic [AW:0] wp;
    logic [AW:0] rp;
  } sfs_fptr_s;
  sfs_fptr_s      f, fn;
  logic [W-1:0]   mem [D];
  logic           full, empty;

  // pointers carry one extra wrap bit so full and empty are distinct
  assign full        = (f.wp[AW] != f.rp[AW]) && (f.wp[AW-1:0] == f.rp[AW-1:0]);
  assign empty       = (f.wp == f.rp);
  assign in_ready_o  = !full;
  assign out_valid_o = !empty;
  assign out_data_o  = mem[f.rp[AW-1:0]];

  always_comb begin
    fn = f;
    if (flush_i) begin
      fn = '0;
    end else begin
      if (in_valid_i && !full) fn.wp = f.wp + 1'b1;
      if (out_ready_i && !empty) fn.rp = f.rp + 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) f <= '0;
    else f <= fn;
    if (in_valid_i && !full && !flush_i) mem[f.wp[AW-1:0]] <= in_data_i;
  end
endmodule // sfs_fifo

module sfs_core #(
  parameter int          ADDR_W         = sfs_pkg::MEM_ADDR_W,       // memory address bits
  parameter int unsigned STAT_WR_CYCLES = sfs_pkg::STATUS_WRITE_CYC, // status write busy time
  parameter int unsigned ERASE_CYCLES   = sfs_pkg::ERASE4K_CYC       // sector erase busy time
) (
  input  wire logic mclk_i,                   // core clock
  input  wire logic reset_i,                  // synchronous reset, high
  input  wire logic cs_n_i,                   // chip select pin, low active
  input  wire logic sclk_i,                   // serial clock pin
  input  wire logic io_line_0_i,              // serial data in
  output logic      io_line_0_o,              // low data bit in dual read
  output logic      io_line_0_oe_o,           // drives io_line_0
  output logic      io_line_1_o,              // serial data out
  output logic      io_line_1_oe_o,           // drives io_line_1
  input  wire logic guard_n_i,                // write guard pin, low active
  output logic [7:0] status_o,                // status byte
  output logic      hard_guard_mode_o         // hard guard mode active
);
  import sfs_pkg::*;

  localparam logic [23:0] ADDR_MASK = 24'((64'd1 << ADDR_W) - 1);
  localparam logic [8:0]  NBLK      = 9'(2 ** (ADDR_W - BLOCK_LSB));

  sfs_state_s  s, n;
  sfs_pins_s   pins_raw;
  logic [7:0]  mem [2 ** ADDR_W];
  logic        rise, fall, cs_up, hgm_now, last_bit;
  logic [7:0]  byte_in, ob, fifo_din, fifo_dout;
  logic        fifo_push, fifo_ready, fifo_valid, fifo_pop;

  // keep the address inside the array so reads roll over to zero
  function automatic logic [23:0] wrap_addr(input logic [23:0] a);
    return a & ADDR_MASK;
  endfunction

  // protect level n guards the top 2**(n-1) 64K blocks; level 0 guards nothing
  function automatic logic prot_hit(input logic [23:0] a, input logic [3:0] bp);
    logic [23:0] am;
    logic [8:0]  cnt;
    am  = wrap_addr(a);
    cnt = (bp > 4'd9) ? 9'h100 : (9'h1 << (bp - 4'h1));
    return (bp != 4'h0) && (({1'b0, am[23:16]} + cnt) >= NBLK);
  endfunction

  assign pins_raw  = '{guard_n: guard_n_i, cs_n: cs_n_i, sclk: sclk_i, si: io_line_0_i};
  // only the second synchroniser stage is looked at
  assign rise      = s.s2.sclk & ~s.sclk_d;
  assign fall      = ~s.s2.sclk & s.sclk_d;
  assign cs_up     = s.s2.cs_n & ~s.cs_d;
  assign hgm_now   = s.lock & ~s.s2.guard_n; // R7
  assign byte_in   = {s.sh[6:0], s.s2.si}; // R21
  assign last_bit  = (s.bitcnt == 3'd7);
  assign fifo_push = s.pf_en & ~s.s2.cs_n;
  assign fifo_din  = mem[s.pf_addr[ADDR_W-1:0]];

  // prefetch runs ahead of the shifter; fifo back-pressure halts the address walk
  sfs_fifo #(.W(8), .D(FIFO_DEPTH)) u_fifo (
    .clk_i       (mclk_i),
    .reset_i     (reset_i),
    .flush_i     (s.s2.cs_n),
    .in_valid_i  (fifo_push),
    .in_ready_o  (fifo_ready),
    .in_data_i   (fifo_din),
    .out_valid_o (fifo_valid),
    .out_ready_i (fifo_pop),
    .out_data_o  (fifo_dout)
  );

  // next-state logic for the whole sequencer
  always_comb begin
    n        = s;
    ob       = s.obyte;
    fifo_pop = 1'b0;
    n.s1     = pins_raw;
    n.s2     = s.s1;
    n.sclk_d = s.s2.sclk;
    n.cs_d   = s.s2.cs_n;
    // self-timed cycle: erase walks one byte a clock, timer sets the minimum length
    if (s.busy) begin
      if (s.timer != 32'h0) n.timer = s.timer - 32'h1;
      if (!s.er_idx[12]) n.er_idx = s.er_idx + 13'h1;
      if (s.timer == 32'h0 && s.er_idx[12]) begin
        n.busy  = 1'b0;
        n.latch = 1'b0; // R4 R17
      end
    end
    if (s.s2.cs_n) begin
      // deselected: drop the transfer and release both lines
      n.ph      = PH_CMD;
      n.bitcnt  = 3'd0;
      n.bytecnt = 2'd0;
      n.pf_en   = 1'b0;
      n.obit    = 3'd0;
      n.oe1     = 1'b0; // R10
      n.oe0     = 1'b0;
      if (cs_up) begin
        n.pend = PD_NONE;
        case (s.pend)
          PD_UNLOCK: begin
            if (!s.busy) n.latch = 1'b1; // R20
          end
          PD_STATUS: begin
            if (s.latch && !s.busy && !hgm_now) begin // R1 R5 R6
              n.lock   = s.new_stat[LOCK_BIT]; // R3
              n.prot   = s.new_stat[PROT_MSB:PROT_LSB];
              n.busy   = 1'b1; // R4
              n.timer  = STAT_WR_CYCLES;
              n.er_idx = SECTOR_DONE;
            end
          end
          PD_ERASE: begin
            if (s.latch && !s.busy && !prot_hit(s.addr, s.prot)) begin // R15 R18
              n.busy    = 1'b1; // R17
              n.timer   = ERASE_CYCLES;
              n.er_idx  = 13'h0;
              n.er_base = s.addr[23:SECTOR_LSB];
            end
          end
          default: ;
        endcase
      end
    end else begin
      if (rise) begin
        n.sh     = byte_in;
        n.bitcnt = s.bitcnt + 3'd1;
        case (s.ph)
          PH_CMD: begin
            if (last_bit) begin
              n.cmd = byte_in;
              n.ph  = PH_SKIP;
              if (byte_in == OP_UNLOCK) n.pend = PD_UNLOCK;
              else if (byte_in == OP_STATUS_WRITE) n.ph = PH_STAT; // R2
              else if (byte_in == OP_READ || byte_in == OP_ERASE) n.ph = PH_ADDR;
              else if ((byte_in == OP_FAST || byte_in == OP_DUAL) && !s.busy) n.ph = PH_ADDR; // R12
            end
          end
          PH_ADDR: begin
            n.addr = {s.addr[22:0], s.s2.si}; // R8
            if (last_bit) begin
              n.bytecnt = s.bytecnt + 2'd1;
              if (s.bytecnt == ADDR_LAST) begin
                n.pf_addr = wrap_addr({s.addr[22:0], s.s2.si});
                n.pf_en   = (s.cmd != OP_ERASE);
                if (s.cmd == OP_READ) n.ph = PH_DATA;
                else if (s.cmd == OP_ERASE) begin
                  n.ph   = PH_SKIP;
                  n.pend = PD_ERASE; // R15
                end else n.ph = PH_DUMMY; // R11 R13
              end
            end
          end
          PH_DUMMY: begin
            if (last_bit) n.ph = PH_DATA; // R11
          end
          PH_STAT: begin
            if (last_bit) begin
              n.new_stat = byte_in;
              n.pend     = PD_STATUS;
              n.ph       = PH_SKIP;
            end
          end
          PH_SKIP: n.pend = PD_NONE; // R16
          default: ;
        endcase
      end
      // data leaves on the falling edge, a fresh byte every 8 or 4 edges
      if (fall && s.ph == PH_DATA) begin
        if (s.obit == 3'd0) begin
          ob       = fifo_valid ? fifo_dout : 8'hff;
          fifo_pop = 1'b1;
        end
        n.io1 = ob[7]; // R21
        n.io0 = ob[6];
        n.oe1 = 1'b1;
        if (s.cmd == OP_DUAL) begin
          n.oe0   = 1'b1; // R13 R14
          n.obyte = {ob[5:0], 2'b00};
          n.obit  = (s.obit == 3'd3) ? 3'd0 : s.obit + 3'd1;
        end else begin
          n.obyte = {ob[6:0], 1'b0};
          n.obit  = s.obit + 3'd1;
        end
      end
      if (fifo_push && fifo_ready) n.pf_addr = wrap_addr(s.pf_addr + 24'h1); // R9
    end
    n.status = {n.lock, 1'b0, n.prot, n.latch, n.busy}; // R19
    n.hgm    = hgm_now;
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      s         <= '0;
      s.s1.cs_n <= 1'b1; // idle select level, so no false select edge follows reset
      s.s2.cs_n <= 1'b1;
      s.cs_d    <= 1'b1;
      s.lock    <= LOCK_RST;
      s.prot    <= PROT_RST;
    end else begin
      s <= n;
    end
  end

  // erase writes ones over the chosen sector, one byte per clock
  always_ff @(posedge mclk_i) begin
    if (s.busy && !s.er_idx[12]) begin
      mem[ADDR_W'({s.er_base, s.er_idx[11:0]})] <= 8'hff; // R15
    end
  end

  assign io_line_1_o       = s.io1;
  assign io_line_1_oe_o    = s.oe1;
  assign io_line_0_o       = s.io0;
  assign io_line_0_oe_o    = s.oe0;
  assign status_o          = s.status;
  assign hard_guard_mode_o = s.hgm;

  a_unlock_sets_latch: assert property (@(posedge mclk_i) disable iff (reset_i) // R20
    cs_up && s.pend == PD_UNLOCK && !s.busy |=> s.latch)
    else $error("unlock did not set the write latch");
  a_status_write_run: assert property (@(posedge mclk_i) disable iff (reset_i) // R6
    cs_up && s.pend == PD_STATUS && s.latch && !s.busy && !hgm_now |=>
    s.busy && s.lock == $past(s.new_stat[7]) && s.prot == $past(s.new_stat[5:2]))
    else $error("status write did not load lock and protect bits");
  a_low_bits_kept: assert property (@(posedge mclk_i) disable iff (reset_i) // R3
    cs_up && s.pend == PD_STATUS && s.latch && !s.busy && !hgm_now |=> ##1
    status_o[1:0] == 2'b11 && status_o[6] == 1'b0)
    else $error("status write touched bits 6, 1 or 0");
  a_hard_guard_block: assert property (@(posedge mclk_i) disable iff (reset_i) // R5
    cs_up && s.pend == PD_STATUS && !s.busy && hgm_now |=>
    $stable(s.lock) && $stable(s.prot) && !s.busy)
    else $error("status write accepted in hard guard mode");
  a_busy_end_clear: assert property (@(posedge mclk_i) disable iff (reset_i) // R17
    $fell(s.busy) |-> !s.latch)
    else $error("write latch still set after timed cycle");
  a_erase_protect: assert property (@(posedge mclk_i) disable iff (reset_i) // R18
    cs_up && s.pend == PD_ERASE && !s.busy && prot_hit(s.addr, s.prot) |=> !s.busy)
    else $error("erase started inside protected area");
  a_erase_sector: assert property (@(posedge mclk_i) disable iff (reset_i) // R15
    cs_up && s.pend == PD_ERASE && s.latch && !s.busy && !prot_hit(s.addr, s.prot) |=>
    s.busy && s.er_base == $past(s.addr[23:12]) && s.er_idx == 13'h0)
    else $error("erase did not start on the addressed sector");
  a_fast_busy_skip: assert property (@(posedge mclk_i) disable iff (reset_i) // R12
    rise && !s.s2.cs_n && s.ph == PH_CMD && last_bit && s.busy &&
    (byte_in == OP_FAST || byte_in == OP_DUAL) |=> s.ph == PH_SKIP)
    else $error("fast or dual read accepted while busy");
  a_release_quiet: assert property (@(posedge mclk_i) disable iff (reset_i) // R10
    s.s2.cs_n |=> !io_line_1_oe_o && !io_line_0_oe_o)
    else $error("data line driven while deselected");
  a_dual_only_line0: assert property (@(posedge mclk_i) disable iff (reset_i) // R14
    io_line_0_oe_o |-> s.cmd == OP_DUAL && s.ph == PH_DATA)
    else $error("second data line driven outside dual read");
  a_addr_wraps: assert property (@(posedge mclk_i) disable iff (reset_i) // R9
    fifo_push && fifo_ready |=> s.pf_addr == wrap_addr($past(s.pf_addr) + 24'h1))
    else $error("read address did not step or wrap");
  a_boundary_drop: assert property (@(posedge mclk_i) disable iff (reset_i) // R16
    rise && !s.s2.cs_n && s.ph == PH_SKIP |=> s.pend == PD_NONE)
    else $error("command kept after extra clock");
endmodule // sfs_core

// ==== sfs_host.sv ====
// sfs_host: behavioural host side of the serial flash link (mode 0, msb first)
// assumes the testbench resolves line 0 from the device enable and feeds it back here
`timescale 1ns/100ps

module sfs_host (
  input  wire logic mclk_i,       // core clock, paces every pin change
  input  wire logic io_line_0_i,  // resolved data line 0
  input  wire logic io_line_1_i,  // data line 1 from the device
  output logic      cs_n_o,       // chip select, low active
  output logic      sclk_o,       // serial clock, idles low between frames
  output logic      si_o,         // data to the device on line 0
  output logic      si_oe_o       // high while the host drives line 0
);
  int half = 8;  // mclk cycles per serial clock phase, 80 ns period

  // idle pins; a released line shows the inverse of its last bit, not a stale copy
  initial begin
    cs_n_o  = 1'b1;
    sclk_o  = 1'b0;
    si_o    = 1'b1;
    si_oe_o = 1'b0;
  end

  // pins only move one small step after a core clock edge
  task automatic tick(input int n);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask

  task automatic pulse();
    tick(half);
    sclk_o = 1'b1;
    tick(half);
    sclk_o = 1'b0;
  endtask

  task automatic begin_f();
    si_oe_o = 1'b1;
    cs_n_o  = 1'b0;
    tick(half);
  endtask

  // bit set while the clock is low, taken by the device on the rise
  task automatic byte_out(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      si_o = b[i];
      pulse();
    end
  endtask

  // sample just before each fall, when the bit shifted on the last fall has settled
  task automatic byte_in(input logic dual, output logic [7:0] b);
    si_oe_o = 1'b0;
    si_o    = ~si_o;
    b       = 8'h00;
    for (int i = 0; i < (dual ? 4 : 8); i++) begin
      tick(half);
      sclk_o = 1'b1;
      tick(half);
      b      = dual ? {b[5:0], io_line_1_i, io_line_0_i} : {b[6:0], io_line_1_i};
      sclk_o = 1'b0;
    end
  endtask

  // extra bits put the select rise off the byte boundary on purpose
  task automatic end_f(input int extra);
    for (int i = 0; i < extra; i++)
      pulse();
    tick(half);
    cs_n_o  = 1'b1;
    si_oe_o = 1'b0;
    si_o    = ~si_o;
    tick(8);
  endtask
endmodule // sfs_host

// ==== tb_top.sv ====
// tb_top: self-checking bench for sfs_core driven through the host link model
// assumes short busy counts and a 16-bit array so erases finish quickly
`timescale 1ns/100ps

module tb_top;
  import sfs_pkg::*;
  logic       mclk, reset, cs_n, sclk, si, io0, io0_o, io0_oe, io1, io1_oe, guard_n, hgm;
  logic [7:0] status;
  int         n_mismatch, checks_done;

  // line 0 carries the device bit whenever it drives, else the host's level
  assign io0 = io0_oe ? io0_o : si;

  sfs_core #(
    .ADDR_W         (16),
    .STAT_WR_CYCLES (20),
    .ERASE_CYCLES   (50)
  ) uut (
    .mclk_i            (mclk),
    .reset_i           (reset),
    .cs_n_i            (cs_n),
    .sclk_i            (sclk),
    .io_line_0_i       (io0),
    .io_line_0_o       (io0_o),
    .io_line_0_oe_o    (io0_oe),
    .io_line_1_o       (io1),
    .io_line_1_oe_o    (io1_oe),
    .guard_n_i         (guard_n),
    .status_o          (status),
    .hard_guard_mode_o (hgm)
  );

  sfs_host u_host (
    .mclk_i      (mclk),
    .io_line_0_i (io0),
    .io_line_1_i (io1),
    .cs_n_o      (cs_n),
    .sclk_o      (sclk),
    .si_o        (si),
    .si_oe_o     ()
  );

  // 200 MHz core clock
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  task automatic conclude();
    $display("mismatches %0d of %0d checks", n_mismatch, checks_done);
    if (n_mismatch == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // bounded poll of one status bit; running out ends the run
  task automatic wait_bit(input int pos, input logic v, input int lim);
    int i;
    for (i = 0; i < lim && status[pos] !== v; i++)
      u_host.tick(1);
    if (status[pos] !== v) begin
      chk("status bit wait", {7'h0, v}, {7'h0, status[pos]});
      conclude();
    end
  endtask

  task automatic cmd1(input logic [7:0] op);
    u_host.begin_f();
    u_host.byte_out(op);
    u_host.end_f(0);
  endtask

  task automatic cmd2(input logic [7:0] op, input logic [7:0] d, input int extra);
    u_host.begin_f();
    u_host.byte_out(op);
    u_host.byte_out(d);
    u_host.end_f(extra);
  endtask

  task automatic addr3(input logic [23:0] a);
    u_host.byte_out(a[23:16]);
    u_host.byte_out(a[15:8]);
    u_host.byte_out(a[7:0]);
  endtask

  task automatic erase(input logic [23:0] a, input int extra);
    cmd1(OP_UNLOCK);
    u_host.begin_f();
    u_host.byte_out(OP_ERASE);
    addr3(a);
    u_host.end_f(extra);
  endtask

  // three bytes of erased data, line enables checked while the last bit stands
  task automatic rd(input logic [7:0] op, input logic [23:0] a, input logic [1:0] oe,
                    input logic data_ok);
    logic [7:0] b;
    u_host.begin_f();
    u_host.byte_out(op);
    addr3(a);
    if (op != OP_READ)
      u_host.byte_out(8'h00);
    repeat (3) begin
      u_host.byte_in(op == OP_DUAL, b);
      if (data_ok)
        chk("read byte", 8'hff, b);
      chk("read line enables", {6'h0, oe}, {6'h0, io1_oe, io0_oe});
    end
    u_host.end_f(0);
    chk("enables after select rise", 8'h00, {6'h0, io1_oe, io0_oe});
  endtask

  // main sequence; reset held 4 clocks
  initial begin
    reset       = 1'b1;
    guard_n     = 1'b1;
    n_mismatch  = 0;
    checks_done = 0;
    u_host.tick(4);
    reset = 1'b0;
    u_host.tick(4);
    chk("status after reset", 8'h00, status);
    cmd2(OP_STATUS_WRITE, 8'h9c, 0);
    chk("status write without latch", 8'h00, status);
    cmd1(OP_UNLOCK);
    chk("latch after unlock", 8'h02, status);
    cmd2(OP_STATUS_WRITE, 8'h9c, 1);
    chk("status write off boundary", 8'h02, status);
    cmd2(OP_STATUS_WRITE, 8'hff, 0);
    wait_bit(0, 1'b1, 20);
    chk("status during write", 8'hbf, status);
    wait_bit(0, 1'b0, 100);
    chk("status after write", 8'hbc, status);
    guard_n = 1'b0;
    cmd1(OP_UNLOCK);
    chk("hard guard entered", 8'h01, {7'h0, hgm});
    cmd2(OP_STATUS_WRITE, 8'h00, 0);
    u_host.tick(30);
    chk("lock and level in hard guard", 8'h2f, {2'b00, status[7:2]});
    chk("busy in hard guard", 8'h00, {7'h0, status[0]});
    guard_n = 1'b1;
    cmd1(OP_UNLOCK);
    chk("hard guard left", 8'h00, {7'h0, hgm});
    cmd2(OP_STATUS_WRITE, 8'h00, 0);
    wait_bit(0, 1'b1, 20);
    wait_bit(0, 1'b0, 100);
    chk("status cleared", 8'h00, status);
    erase(24'h000000, 0);
    wait_bit(0, 1'b1, 20);
    chk("latch during erase", 8'h03, {6'h0, status[1:0]});
    wait_bit(0, 1'b0, 5000);
    chk("status after erase", 8'h00, status);
    erase(24'h00f000, 0);
    wait_bit(0, 1'b1, 20);
    rd(OP_FAST, 24'h000000, 2'b00, 1'b0);
    rd(OP_DUAL, 24'h000000, 2'b00, 1'b0);
    chk("busy kept after refused reads", 8'h03, {6'h0, status[1:0]});
    wait_bit(0, 1'b0, 5000);
    chk("status after second erase", 8'h00, status);
    rd(OP_READ, 24'h00fffe, 2'b10, 1'b1);
    rd(OP_FAST, 24'h000010, 2'b10, 1'b1);
    rd(OP_DUAL, 24'h00f0f0, 2'b11, 1'b1);
    erase(24'h002000, 1);
    u_host.tick(30);
    chk("erase off boundary", 8'h02, status);
    cmd2(OP_STATUS_WRITE, 8'h04, 0);
    wait_bit(0, 1'b1, 20);
    wait_bit(0, 1'b0, 100);
    chk("protect level one", 8'h04, status);
    erase(24'h001000, 0);
    u_host.tick(30);
    chk("erase into protected area", 8'h06, status);
    conclude();
  end
endmodule // tb_top
